// file: verilog/cms_top.sv
/*
 Charger mode sequencer: battery-only power-up, low-power/performance mode,
 system droop assist mode, input power-up sequence and input-good indicator.
 Assumes analog comparators deliver asynchronous levels, which are synchronised here,
 and an AXI4-Lite master that keeps one read and one write outstanding at most.
*/
// Notes on behaviour
// - Battery alone above release closes switch.
// - Reset gives low-power mode, regulator off.
// - Performance mode keeps regulator on always.
// - Thresholds start assist discharge and throttle.
// - Assist entry needs bits clear, pin high.
// - Mode bit set or pin low exits.
// - Fault in assist sets mode bit, exits.
// - 50 ms above threshold: regulator, input-good.
// - Limits then cell configuration, in order.
// - Converter starts at 150 ms, after limits.
// - Input-good needs window and no fault.
`timescale 1ns/100ps
module cms_top
    import cms_pkg::*;
#(
    parameter int TICK_CYCLES = CMS_TICK_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cms_sense_s sense,
    output logic battery_switch,
    output logic gate_drive_regulator,
    output logic converter_enable,
    output logic input_good_o,
    output logic input_good_oe,
    output logic assist_discharge,
    output logic processor_throttle_n,
    output logic system_droop_assist,
    output logic irq
);

    cms_sense_s sense_meta;
    cms_sense_s s;
    logic tick;
    logic [3:0] ctrl;
    logic [15:0] limits;
    logic [CMS_IRQ_W-1:0] irq_stat;
    logic [CMS_IRQ_W-1:0] irq_mask;
    logic [CMS_IRQ_W-1:0] events;
    cms_seq_e seq;
    logic [7:0] ms_count;
    logic limits_set;
    logic good_now;
    logic assist_ok;
    logic fault_exit;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    ////////////////////////////////////////////////////////////////////////////////
    // The first stage feeds only the second stage.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sense_meta <= '0;
            s <= '0;
        end
        else
        begin
            sense_meta <= sense;
            s <= sense_meta;
        end
    end

    cms_ms_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data are taken in either order.
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            s_axi_wready <= !w_held && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr > CMS_OFF_IRQ_MASK || aw_addr[1:0] != 2'h0) ?
                    2'h2 : 2'h0;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = do_write && aw_addr == off && w_strb[0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Control register; hardware setting the mode bit wins over any software write.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= CMS_CTRL_RESET;
        end
        else
        begin
            if (wr_hit(CMS_OFF_CTRL))
            begin
                ctrl <= w_data[3:0];
            end
            if (fault_exit)
            begin
                ctrl[CMS_CTRL_MODE_SEL] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            limits <= 16'h0000;
        end
        else
        begin
            if (wr_hit(CMS_OFF_LIMITS))
            begin
                limits[7:0] <= w_data[7:0];
            end
            if (do_write && aw_addr == CMS_OFF_LIMITS && w_strb[1])
            begin
                limits[15:8] <= w_data[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky interrupts: a new event wins over a clear in the same cycle.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat <= (irq_stat & ~(wr_hit(CMS_OFF_IRQ_STAT) ?
                w_data[CMS_IRQ_W-1:0] : '0)) | events;
            if (wr_hit(CMS_OFF_IRQ_MASK))
            begin
                irq_mask <= w_data[CMS_IRQ_W-1:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                unique case (s_axi_araddr)
                    CMS_OFF_CTRL: s_axi_rdata <= {28'h0, ctrl};
                    CMS_OFF_LIMITS: s_axi_rdata <= {16'h0, limits};
                    CMS_OFF_STATUS: s_axi_rdata <= {24'h0, seq, system_droop_assist,
                        input_good_oe};
                    CMS_OFF_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat};
                    CMS_OFF_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask};
                    default:
                    begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input-good window and faults.
    assign good_now = s.input_above_conv && !s.input_above_ovp && !s.fault;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seq <= CMS_IDLE;
            ms_count <= 8'h00;
            limits_set <= 1'b0;
        end
        else if (!s.input_above_conv)
        begin
            seq <= CMS_IDLE;
            ms_count <= 8'h00;
            limits_set <= 1'b0;
        end
        else
        begin
            if (tick && ms_count != 8'hFF)
            begin
                ms_count <= ms_count + 8'h01;
            end
            unique case (seq)
                CMS_IDLE: seq <= CMS_WAIT_REG;
                CMS_WAIT_REG:
                    if (ms_count >= 8'(CMS_REG_ON_MS))
                    begin
                        seq <= CMS_LIMITS;
                    end
                CMS_LIMITS:
                begin
                    limits_set <= 1'b1;
                    seq <= CMS_CELLS;
                end
                CMS_CELLS: seq <= CMS_WAIT_CONV;
                CMS_WAIT_CONV:
                    if (ms_count >= 8'(CMS_CONV_ON_MS) && limits_set)
                    begin
                        seq <= CMS_RUN;
                    end
                CMS_RUN: seq <= CMS_RUN;
                default: seq <= CMS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assist entry conditions.
    assign assist_ok = !ctrl[CMS_CTRL_MODE_SEL] && !ctrl[CMS_CTRL_OTG_EN] &&
        s.source_assist_pin && !s.input_above_conv && s.battery_above_release;
    assign fault_exit = system_droop_assist && s.fault;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            system_droop_assist <= 1'b0;
            battery_switch <= 1'b0;
            gate_drive_regulator <= 1'b0;
            converter_enable <= 1'b0;
            input_good_o <= 1'b0;
            input_good_oe <= 1'b0;
            assist_discharge <= 1'b0;
            processor_throttle_n <= 1'b1;
            events <= '0;
        end
        else
        begin
            system_droop_assist <= assist_ok && !s.fault;
            battery_switch <= s.battery_above_release;
            gate_drive_regulator <= !ctrl[CMS_CTRL_LOW_POWER] ||
                (seq != CMS_IDLE && seq != CMS_WAIT_REG);
            // A dropout stops the converter at once, not one cycle after the restart.
            converter_enable <= seq == CMS_RUN && s.input_above_conv;
            input_good_o <= 1'b1;
            // Driven open drain: enable drives it high; released, the board pulls it low.
            input_good_oe <= good_now && seq != CMS_IDLE && seq != CMS_WAIT_REG;
            assist_discharge <= system_droop_assist && s.sys_below_assist_level;
            processor_throttle_n <= !(system_droop_assist && s.sys_below_throttle_level);
            events[CMS_IRQ_INPUT_GOOD] <= seq == CMS_WAIT_REG && ms_count >= 8'(CMS_REG_ON_MS);
            events[CMS_IRQ_CONV_START] <= seq == CMS_WAIT_CONV &&
                ms_count >= 8'(CMS_CONV_ON_MS) && limits_set;
            events[CMS_IRQ_ASSIST_EXIT] <= system_droop_assist && !assist_ok;
            events[CMS_IRQ_FAULT] <= fault_exit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fault forces exit.
    a_fault_exit: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_exit |=> ctrl[CMS_CTRL_MODE_SEL] ##1 !system_droop_assist)
        else $error("Fault did not force assist exit.");

    a_mode_exit: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl[CMS_CTRL_MODE_SEL] || !s.source_assist_pin) |=> !system_droop_assist)
        else $error("Assist mode held after exit request.");

    a_assist_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        system_droop_assist |-> $past(!ctrl[CMS_CTRL_OTG_EN] && s.source_assist_pin))
        else $error("Assist entered without its conditions.");

    a_conv_order: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(converter_enable) |-> limits_set && ms_count >= 8'(CMS_CONV_ON_MS))
        else $error("Converter started early.");

    a_good_window: assert property (@(posedge aclk) disable iff (!aresetn)
        input_good_oe |-> $past(good_now))
        else $error("Input-good asserted outside its window.");

    a_seq_order: assert property (@(posedge aclk) disable iff (!aresetn)
        seq == CMS_LIMITS && s.input_above_conv |=> seq == CMS_CELLS)
        else $error("Cell step did not follow limit step.");

    a_reg_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(input_good_oe) |-> ms_count >= 8'(CMS_REG_ON_MS))
        else $error("Input-good before 50 ms.");

    a_dropout: assert property (@(posedge aclk) disable iff (!aresetn)
        !s.input_above_conv |=> seq == CMS_IDLE && ms_count == 8'h00)
        else $error("Dropout did not restart sequence.");

    a_perf_reg: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl[CMS_CTRL_LOW_POWER] |=> gate_drive_regulator)
        else $error("Regulator off in performance mode.");

    a_battery_sw: assert property (@(posedge aclk) disable iff (!aresetn)
        s.battery_above_release |=> battery_switch)
        else $error("Battery switch not closed.");

endmodule

// file: verilog/cms_pkg.sv
/*
 Package for the charger mode sequencer: register map, field layout, reset values and timing.
 Assumes a 100 MHz clock and 32-bit AXI4-Lite register access.
*/
package cms_pkg;

    localparam logic [7:0] CMS_OFF_CTRL = 8'h00;
    localparam logic [7:0] CMS_OFF_LIMITS = 8'h04;
    localparam logic [7:0] CMS_OFF_STATUS = 8'h08;
    localparam logic [7:0] CMS_OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] CMS_OFF_IRQ_MASK = 8'h10;

    // Control register bit positions.
    localparam int CMS_CTRL_LOW_POWER = 0;
    localparam int CMS_CTRL_MODE_SEL = 1;
    localparam int CMS_CTRL_OTG_EN = 2;
    localparam int CMS_CTRL_MON_EN = 3;
    localparam logic [3:0] CMS_CTRL_RESET = 4'h3;

    // Interrupt bit positions.
    localparam int CMS_IRQ_INPUT_GOOD = 0;
    localparam int CMS_IRQ_CONV_START = 1;
    localparam int CMS_IRQ_ASSIST_EXIT = 2;
    localparam int CMS_IRQ_FAULT = 3;
    localparam int CMS_IRQ_W = 4;

    localparam int CMS_CLK_HZ = 100000000;
    localparam int CMS_TICK_MS = 1;
    localparam int CMS_TICK_CYCLES = CMS_CLK_HZ / 1000 * CMS_TICK_MS;
    localparam int CMS_REG_ON_MS = 50;
    localparam int CMS_CONV_ON_MS = 150;

    typedef enum logic [5:0] {
        CMS_IDLE = 6'h01,
        CMS_WAIT_REG = 6'h02,
        CMS_LIMITS = 6'h04,
        CMS_CELLS = 6'h08,
        CMS_WAIT_CONV = 6'h10,
        CMS_RUN = 6'h20
    } cms_seq_e;

    typedef struct packed {
        logic input_above_conv;
        logic input_above_ovp;
        logic battery_above_release;
        logic fault;
        logic source_assist_pin;
        logic sys_below_assist_level;
        logic sys_below_throttle_level;
    } cms_sense_s;

endpackage

// file: verilog/cms_ms_tick.sv
/*
 Millisecond tick divider for the charger mode sequencer.
 Assumes one free-running clock; the tick is a one-cycle enable.
*/
`timescale 1ns/100ps
module cms_ms_tick
    import cms_pkg::*;
#(
    parameter int CYCLES = CMS_TICK_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);

    logic [31:0] count;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count <= 32'h0;
            tick <= 1'b0;
        end
        else if (count == 32'(CYCLES - 1))
        begin
            count <= 32'h0;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 32'h1;
            tick <= 1'b0;
        end
    end

endmodule

// file: verif/cms_analog_model.sv
/*
 Analog front end model for the charger mode sequencer: turns bench commands into sense levels.
 Assumes the bench changes its commands just after a clock edge.
*/
`timescale 1ns/100ps
module cms_analog_model
    import cms_pkg::*;
(
    input wire logic plug,
    input wire logic over_volt,
    input wire logic batt_ok,
    input wire logic fault_in,
    input wire logic assist_pin,
    input wire logic [1:0] droop,
    input wire logic input_good_o,
    input wire logic input_good_oe,
    output cms_sense_s sense,
    output logic input_good_pin
);
    always_comb
    begin
        sense.input_above_conv = plug;
        sense.input_above_ovp = plug & over_volt;
        sense.battery_above_release = batt_ok;
        sense.fault = fault_in;
        sense.source_assist_pin = assist_pin;
        sense.sys_below_assist_level = (droop != 2'h0);
        sense.sys_below_throttle_level = (droop == 2'h2);
    end

    // The board pulls the released pin low, so a floating driver never reads as good.
    assign input_good_pin = input_good_oe ? input_good_o : 1'b0;
endmodule

// file: verif/tb_top.sv
/*
 Self-checking bench for the charger mode sequencer, driving AXI4-Lite and the sense model.
 Assumes a shortened millisecond tick, so the whole input power-up sequence fits a short run.
*/
`timescale 1ns/100ps
module tb_top
    import cms_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    cms_sense_s sense;
    logic battery_switch, gate_drive_regulator, converter_enable, input_good_o, input_good_oe;
    logic assist_discharge, processor_throttle_n, system_droop_assist, irq, input_good_pin;
    logic plug = 1'b0;
    logic over_volt = 1'b0;
    logic batt_ok = 1'b0;
    logic fault_in = 1'b0;
    logic assist_pin = 1'b0;
    logic [1:0] droop = 2'h0;
    int n_fail = 0;
    int total_checks = 0;
    logic [31:0] d;
    logic [1:0] r;

    always #5 aclk = ~aclk;

    // A 20-cycle tick stands in for the millisecond; all delays scale with it.
    cms_top #(.TICK_CYCLES(20)) cms_top_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sense(sense),
        .battery_switch(battery_switch), .gate_drive_regulator(gate_drive_regulator),
        .converter_enable(converter_enable), .input_good_o(input_good_o),
        .input_good_oe(input_good_oe), .assist_discharge(assist_discharge),
        .processor_throttle_n(processor_throttle_n),
        .system_droop_assist(system_droop_assist), .irq(irq));

    cms_analog_model cms_analog_model_i (.plug(plug), .over_volt(over_volt), .batt_ok(batt_ok),
        .fault_in(fault_in), .assist_pin(assist_pin), .droop(droop),
        .input_good_o(input_good_o), .input_good_oe(input_good_oe), .sense(sense),
        .input_good_pin(input_good_pin));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // A hung handshake counts as a mismatch instead of stalling the run.
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        int n;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok) && n < 100)
        begin
            @(posedge aclk);
            n++;
            if (!aw_ok && s_axi_awready)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (!s_axi_bvalid && n < 100);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 100)
            n_fail++;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (!s_axi_arready && n < 100);
        s_axi_arvalid <= 1'b0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (!s_axi_rvalid && n < 100);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 100)
            n_fail++;
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        n_fail++;
        summarize();
    end

    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CMS_OFF_CTRL, d, r);
        chk("ctrl reset", d, {28'h0000000, CMS_CTRL_RESET});
        chk("regulator reset", 32'(gate_drive_regulator), 32'h0);
        chk("throttle reset", 32'(processor_throttle_n), 32'h1);
        wr(CMS_OFF_IRQ_MASK, 32'h0, r);
        $display("test reset done");
        batt_ok <= 1'b1;
        settle(8);
        chk("switch closed", 32'(battery_switch), 32'h1);
        batt_ok <= 1'b0;
        settle(8);
        chk("switch open", 32'(battery_switch), 32'h0);
        batt_ok <= 1'b1;
        $display("test battery done");
        wr(CMS_OFF_CTRL, 32'h2, r);
        settle(4);
        chk("regulator on", 32'(gate_drive_regulator), 32'h1);
        settle(50);
        chk("regulator held", 32'(gate_drive_regulator), 32'h1);
        wr(CMS_OFF_CTRL, 32'h3, r);
        settle(4);
        chk("regulator off", 32'(gate_drive_regulator), 32'h0);
        $display("test power mode done");
        wr(CMS_OFF_LIMITS, 32'h00001234, r);
        rd(CMS_OFF_LIMITS, d, r);
        chk("limits", d, 32'h00001234);
        wr(CMS_OFF_CTRL, 32'h1, r);
        settle(8);
        chk("no assist pin low", 32'(system_droop_assist), 32'h0);
        wr(CMS_OFF_CTRL, 32'h5, r);
        assist_pin <= 1'b1;
        settle(8);
        chk("no assist otg set", 32'(system_droop_assist), 32'h0);
        wr(CMS_OFF_CTRL, 32'h1, r);
        settle(8);
        chk("assist entered", 32'(system_droop_assist), 32'h1);
        rd(CMS_OFF_STATUS, d, r);
        chk("status assist", 32'(d[1]), 32'h1);
        droop <= 2'h1;
        settle(8);
        chk("discharge", 32'(assist_discharge), 32'h1);
        chk("no throttle", 32'(processor_throttle_n), 32'h1);
        droop <= 2'h2;
        settle(8);
        chk("throttle", 32'(processor_throttle_n), 32'h0);
        droop <= 2'h0;
        assist_pin <= 1'b0;
        settle(8);
        chk("exit by pin", 32'(system_droop_assist), 32'h0);
        rd(CMS_OFF_IRQ_STAT, d, r);
        chk("exit event", d & 32'h4, 32'h4);
        chk("irq masked", 32'(irq), 32'h0);
        wr(CMS_OFF_IRQ_MASK, 32'h4, r);
        settle(4);
        chk("irq raised", 32'(irq), 32'h1);
        wr(CMS_OFF_IRQ_STAT, 32'h4, r);
        settle(4);
        rd(CMS_OFF_IRQ_STAT, d, r);
        chk("event cleared", d & 32'h4, 32'h0);
        chk("irq cleared", 32'(irq), 32'h0);
        assist_pin <= 1'b1;
        settle(8);
        chk("assist again", 32'(system_droop_assist), 32'h1);
        wr(CMS_OFF_CTRL, 32'h3, r);
        settle(8);
        chk("exit by bit", 32'(system_droop_assist), 32'h0);
        $display("test assist done");
        wr(CMS_OFF_CTRL, 32'h1, r);
        settle(8);
        fault_in <= 1'b1;
        settle(8);
        chk("fault exit", 32'(system_droop_assist), 32'h0);
        rd(CMS_OFF_CTRL, d, r);
        chk("mode bit forced", 32'(d[CMS_CTRL_MODE_SEL]), 32'h1);
        rd(CMS_OFF_IRQ_STAT, d, r);
        chk("fault event", d & 32'h8, 32'h8);
        fault_in <= 1'b0;
        assist_pin <= 1'b0;
        $display("test fault done");
        rd(8'h40, d, r);
        chk("unmapped read resp", 32'(r), 32'h2);
        chk("unmapped read data", d, 32'h0);
        wr(8'h44, 32'hFFFFFFFF, r);
        chk("unmapped write resp", 32'(r), 32'h2);
        $display("test unmapped done");
        plug <= 1'b1;
        settle(900);
        chk("good not early", 32'(input_good_oe), 32'h0);
        chk("pin low", 32'(input_good_pin), 32'h0);
        settle(200);
        chk("good after delay", 32'(input_good_oe), 32'h1);
        chk("pin high", 32'(input_good_pin), 32'h1);
        chk("regulator at delay", 32'(gate_drive_regulator), 32'h1);
        settle(1800);
        chk("converter not early", 32'(converter_enable), 32'h0);
        settle(200);
        chk("converter started", 32'(converter_enable), 32'h1);
        rd(CMS_OFF_IRQ_STAT, d, r);
        chk("power-up events", d & 32'h3, 32'h3);
        over_volt <= 1'b1;
        settle(8);
        chk("good off overvolt", 32'(input_good_oe), 32'h0);
        over_volt <= 1'b0;
        plug <= 1'b0;
        settle(8);
        chk("converter off", 32'(converter_enable), 32'h0);
        rd(CMS_OFF_STATUS, d, r);
        chk("seq restarted", 32'(d[7:2]), 32'(CMS_IDLE));
        plug <= 1'b1;
        settle(900);
        chk("good not early again", 32'(input_good_oe), 32'h0);
        plug <= 1'b0;
        settle(8);
        $display("test input done");
        summarize();
    end
endmodule
